//--- inc/wdhc_pkg.sv
// Purpose: constants and types for the watchdog and halt control block
// Assumes: 8-bit register port, one clock domain
// Notes: none
package wdhc_pkg;
  // =====================================================================
  // register map
  localparam logic [1:0] WDHC_ADDR_SELECT = 2'h0;
  localparam logic [1:0] WDHC_ADDR_STATUS = 2'h1;
  localparam logic [7:0] WDHC_SELECT_RST = 8'h07;
  localparam int WDHC_PS_LSB = 0;
  localparam int WDHC_PS_W = 3;
  localparam int WDHC_STAT_PDF = 0;
  localparam int WDHC_STAT_TO = 1;
  // =====================================================================
  // timing
  localparam int WDHC_FIXED_DIV = 256;
  localparam int WDHC_FIXED_BITS = 8;
  localparam int WDHC_INSTR_DIV = 4;
  localparam int WDHC_WAKE_CYCLES = 1024;
  localparam int WDHC_WAKE_W = 11;
  localparam int WDHC_PRE_W = 8;
  // =====================================================================
  // clear modes and states
  typedef enum logic {WDHC_KICK_ONE, WDHC_KICK_TWO} wdhc_kick_t;
  typedef enum logic [1:0] {WDHC_RUN, WDHC_HALTED, WDHC_WAKE} wdhc_state_t;
  typedef struct packed {
    logic kickSingle;
    logic kickFirst;
    logic kickSecond;
    logic haltInstr;
  } wdhc_core_t;
endpackage : wdhc_pkg

//--- src/wdhc_top.sv
// Purpose: watchdog timer with prescaler, halt entry and wake-up control
// Assumes: clk is the system clock; the oscillator tick is synchronous
// Notes: build options are parameters; only the select register is written

// =====================================================================
// Function
// (R1) watchdog clocked by oscillator tick or instruction clock (clk/4)
// (R2) disabled watchdog ignores all watchdog operations, never times out
// (R3) oscillator source passes a fixed divide-by-256 before the prescaler
// (R4) select bits 2..0 set prescale ratio 2 to the field value
// (R5) instruction clock source stops counting while halted
// (R6) select bits 7..3 are plain storage for software flags
// (R7) overflow while running gives chip reset and sets time-out flag
// (R8) overflow while halted gives warm reset of program counter and stack
// (R9) external reset, clear sequence or halt clear counter and prescaler
// (R10) single-clear mode clears on each single clear instruction
// (R11) two-clear mode clears only after both clear instructions
// (R12) halt stops system clock; watchdog oscillator keeps running
// (R13) halt leaves memory, registers and ports unchanged
// (R14) halt entry clears counter and prescaler, counting restarts at zero
// (R15) halt sets power-down flag and clears time-out flag
// (R16) halt pin driven high while halted to disable external memory
// (R17) leave halt on reset, interrupt, port A fall or overflow
// (R18) power-down flag cleared at power-up and by single clear instruction
// (R19) port A bits wake by build mask; resume at next instruction
// (R20) disabled or stack-full interrupt wake resumes next instruction
// (R21) wake waits 1024 system clocks; vectored wake one cycle more
// (R22) interrupt already pending at halt entry cannot wake the device
// (R23) time-out flag cleared at power-up, single clear and halt
// (R24) build options are synthesis parameters, not software bits
module wdhc_top #(
  parameter bit USE_OSC = 1'b1,
  parameter bit WDT_ENABLE = 1'b1,
  parameter bit OSC_ENABLE = 1'b1,
  parameter wdhc_pkg::wdhc_kick_t KICK_MODE = wdhc_pkg::WDHC_KICK_ONE,
  parameter logic [7:0] WAKE_MASK = 8'hFF,
  parameter int WAKE_CYCLES = wdhc_pkg::WDHC_WAKE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic externalInitPin_n,
  input wire logic oscTick,
  input wire wdhc_pkg::wdhc_core_t core,
  input wire logic [7:0] portA,
  input wire logic irqPending,
  input wire logic irqEnabled,
  input wire logic stackFull,
  input wire logic [1:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  output logic chipReset,
  output logic warmReset,
  output logic haltPin,
  output logic sysClkRun,
  output logic resumeNext,
  output logic resumeVector,
  output logic powerdownFlag,
  output logic watchdogExpiredFlag
);
  // =====================================================================
  // decode
  wdhc_pkg::wdhc_state_t state, next_state;
  logic [7:0] watchdogSelect;
  logic [1:0] instrDiv;
  logic [wdhc_pkg::WDHC_FIXED_BITS-1:0] fixedDiv;
  logic [wdhc_pkg::WDHC_PRE_W-1:0] prescale;
  logic [wdhc_pkg::WDHC_WAKE_W-1:0] wakeCnt;
  logic firstSeen, secondSeen;
  logic irqBlocked;
  logic vectorWake, extraCycle;
  logic [7:0] portPrev;
  logic extInit;
  wire halted = (state == wdhc_pkg::WDHC_HALTED);
  wire running = (state == wdhc_pkg::WDHC_RUN);
  wire haltNow = running && core.haltInstr;
  wire [2:0] psSel = watchdogSelect[wdhc_pkg::WDHC_PS_LSB +:
                                    wdhc_pkg::WDHC_PS_W];
  // single kick or completed pair, ignored when disabled [R2]
  wire pairDone = (firstSeen || core.kickFirst) &&
                  (secondSeen || core.kickSecond); // [R11]
  wire kickNow = WDT_ENABLE && running &&
                 ((KICK_MODE == wdhc_pkg::WDHC_KICK_ONE) ? core.kickSingle
                                                         : pairDone); // [R10]
  wire singleClr = WDT_ENABLE && running && core.kickSingle &&
                   (KICK_MODE == wdhc_pkg::WDHC_KICK_ONE);
  // clears of counter and prescaler
  wire wdClear = extInit || kickNow || haltNow; // [R9] [R14]

  // =====================================================================
  // watchdog clock source and overflow
  // the instruction clock stops with the system clock in halt
  wire instrWrap = (instrDiv == 2'(wdhc_pkg::WDHC_INSTR_DIV - 1));
  wire instrTick = instrWrap && !halted; // [R1] [R5] [R12]
  wire oscSource = USE_OSC && OSC_ENABLE; // [R24]
  wire oscOk = OSC_ENABLE && oscTick;
  wire srcTick = oscSource ? oscOk : instrTick; // [R1]
  wire fixedWrap = &fixedDiv;
  wire fixedTick = srcTick && fixedWrap; // [R3]
  wire baseTick = oscSource ? fixedTick : srcTick;
  wire [wdhc_pkg::WDHC_PRE_W-1:0] psLast =
    wdhc_pkg::WDHC_PRE_W'((1 << psSel) - 1); // [R4]
  wire psWrap = (prescale == psLast);
  wire liveState = running || halted;
  // a clear in the same cycle cancels the overflow
  wire overflow = WDT_ENABLE && baseTick && psWrap && !wdClear &&
                  liveState; // [R2]
  wire runOverflow = overflow && running; // [R7]
  wire haltOverflow = overflow && halted; // [R8]

  // =====================================================================
  // wake sources
  wire [7:0] portFall = portPrev & ~portA & WAKE_MASK; // [R19]
  wire portWake = |portFall;
  wire irqWake = irqPending && !irqBlocked; // [R22]
  wire wakeEvent = halted && (irqWake || portWake); // [R17]
  wire wakeDone = (wakeCnt == wdhc_pkg::WDHC_WAKE_W'(WAKE_CYCLES - 1));
  wire inWake = (state == wdhc_pkg::WDHC_WAKE);
  wire vectorNext = irqWake && irqEnabled && !stackFull; // [R20]

  // =====================================================================
  // register decode
  wire selectHit = (addr == wdhc_pkg::WDHC_ADDR_SELECT);
  wire statusHit = (addr == wdhc_pkg::WDHC_ADDR_STATUS);
  wire selWr = wrStb && selectHit;
  wire selReset = rst || extInit || runOverflow;
  wire [7:0] statusRd = {6'h00, watchdogExpiredFlag, powerdownFlag};
  wire [7:0] rdMux = selectHit ? watchdogSelect :
                     statusHit ? statusRd : 8'h00;
  wire [7:0] next_rdData = rdStb ? rdMux : 8'h00;

  // =====================================================================
  // state machine
  always_comb begin
    next_state = state;
    unique case (state)
      wdhc_pkg::WDHC_RUN: begin
        if (core.haltInstr) begin
          next_state = wdhc_pkg::WDHC_HALTED;
        end
      end
      wdhc_pkg::WDHC_HALTED: begin
        if (wakeEvent) begin
          next_state = wdhc_pkg::WDHC_WAKE; // [R21]
        end else if (overflow) begin
          next_state = wdhc_pkg::WDHC_RUN; // [R8]
        end
      end
      wdhc_pkg::WDHC_WAKE: begin
        if (wakeDone && !(vectorWake && !extraCycle)) begin
          next_state = wdhc_pkg::WDHC_RUN;
        end
      end
    endcase
    if (extInit) begin
      next_state = wdhc_pkg::WDHC_RUN; // [R17]
    end
  end

  // registered external init pin, level sensitive
  always_ff @(posedge clk) begin
    if (rst) begin
      extInit <= 1'b0;
    end else begin
      extInit <= !externalInitPin_n; // [R9] [R17]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= wdhc_pkg::WDHC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // =====================================================================
  // dividers and watchdog counter
  always_ff @(posedge clk) begin
    if (rst || extInit) begin
      instrDiv <= 2'h0;
    end else begin
      instrDiv <= instrDiv + 2'h1;
    end
  end

  // clears always win over counting
  wire cntClear = rst || wdClear || overflow;
  wire cntStep = WDT_ENABLE && srcTick;

  always_ff @(posedge clk) begin
    if (cntClear) begin
      fixedDiv <= '0; // [R9]
    end else if (cntStep) begin
      fixedDiv <= fixedDiv + 1'b1; // [R3]
    end
  end

  always_ff @(posedge clk) begin
    if (cntClear) begin
      prescale <= '0; // [R14]
    end else if (cntStep && baseTick) begin
      prescale <= prescale + 1'b1; // [R4]
    end
  end

  // pair progress is forgotten on any clear except an overflow
  wire pairClear = rst || wdClear;
  wire pairTrack = WDT_ENABLE && running;

  always_ff @(posedge clk) begin
    if (pairClear) begin
      firstSeen <= 1'b0;
    end else if (pairTrack && core.kickFirst) begin
      firstSeen <= 1'b1; // [R11]
    end
  end

  always_ff @(posedge clk) begin
    if (pairClear) begin
      secondSeen <= 1'b0;
    end else if (pairTrack && core.kickSecond) begin
      secondSeen <= 1'b1; // [R11]
    end
  end

  // =====================================================================
  // register port
  // select returns to its reset value on any chip reset
  always_ff @(posedge clk) begin
    if (selReset) begin
      watchdogSelect <= wdhc_pkg::WDHC_SELECT_RST; // [R7] [R9]
    end else if (selWr) begin
      watchdogSelect <= wrData; // [R6]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData <= 8'h00;
    end else begin
      rdData <= next_rdData;
    end
  end

  // =====================================================================
  // flags: a halt or clear in the same cycle cancels the time-out
  wire tofSet = overflow; // [R7] [R8]
  wire tofClr = haltNow || singleClr || (extInit && halted); // [R15] [R23]
  wire pdfSet = haltNow; // [R15]
  wire pdfClr = singleClr; // [R18]
  wire next_powerdownFlag = pdfSet ? 1'b1 : pdfClr ? 1'b0 : powerdownFlag;
  wire next_watchdogExpiredFlag = tofSet ? 1'b1 :
                                  tofClr ? 1'b0 : watchdogExpiredFlag;

  always_ff @(posedge clk) begin
    if (rst) begin
      powerdownFlag <= 1'b0; // [R18]
    end else begin
      powerdownFlag <= next_powerdownFlag;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      watchdogExpiredFlag <= 1'b0; // [R23]
    end else begin
      watchdogExpiredFlag <= next_watchdogExpiredFlag;
    end
  end

  // =====================================================================
  // wake sequencing
  // idle-high start value flags a fall on any WAKE_MASK bit of port A that is already low right after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      portPrev <= 8'hFF;
    end else begin
      portPrev <= portA;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irqBlocked <= 1'b0;
    end else if (haltNow) begin
      irqBlocked <= irqPending; // [R22]
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !inWake) begin
      wakeCnt <= '0;
    end else if (!wakeDone) begin
      wakeCnt <= wakeCnt + 1'b1; // [R21]
    end
  end

  // vectored wake holds its exit one more cycle
  always_ff @(posedge clk) begin
    if (rst || !inWake) begin
      extraCycle <= 1'b0;
    end else if (wakeDone) begin
      extraCycle <= 1'b1; // [R21]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vectorWake <= 1'b0;
    end else if (!inWake && wakeEvent) begin
      vectorWake <= vectorNext; // [R20]
    end
  end

  wire leaveWake = inWake && (next_state == wdhc_pkg::WDHC_RUN) &&
                   !extInit;

  // =====================================================================
  // reset, halt and resume outputs
  wire next_chipReset = extInit || runOverflow; // [R7]
  wire next_warmReset = haltOverflow; // [R8]
  wire next_haltPin = (next_state == wdhc_pkg::WDHC_HALTED); // [R16]
  wire next_sysClkRun = !next_haltPin; // [R12] [R13]
  wire next_resumeNext = leaveWake && !vectorWake; // [R19] [R20]
  wire next_resumeVector = leaveWake && vectorWake; // [R21]

  always_ff @(posedge clk) begin
    if (rst) begin
      chipReset <= 1'b1;
    end else begin
      chipReset <= next_chipReset;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      warmReset <= 1'b0;
    end else begin
      warmReset <= next_warmReset;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      haltPin <= 1'b0;
    end else begin
      haltPin <= next_haltPin;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sysClkRun <= 1'b1;
    end else begin
      sysClkRun <= next_sysClkRun;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resumeNext <= 1'b0;
    end else begin
      resumeNext <= next_resumeNext;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resumeVector <= 1'b0;
    end else begin
      resumeVector <= next_resumeVector;
    end
  end
endmodule : wdhc_top

//--- test/wdhc_core_model.sv
// Purpose: core side issuing clear and halt instruction pulses
// Assumes: one op per go pulse
// Notes: op 0 single, 1 first, 2 second, 3 halt
module wdhc_core_model (
  input wire logic clk,
  input wire logic [1:0] op,
  input wire logic go,
  output wdhc_pkg::wdhc_core_t core
);
  timeunit 1ns;
  timeprecision 1ps;
  initial core = '0;
  // one-cycle instruction pulse; kicks issued in time by bench
  always @(posedge clk) begin
    core <= '0;
    if (go) core[2'h3 - op] <= 1'b1;
  end
endmodule : wdhc_core_model

//--- test/wdhc_asserts.sv
// Purpose: port assertions for the watchdog block
// Assumes: one clock, rst synchronous high
// Notes: bound to wdhc_top
module wdhc_asserts #(
  parameter wdhc_pkg::wdhc_kick_t KICK_MODE = wdhc_pkg::WDHC_KICK_ONE
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic externalInitPin_n,
  input wire wdhc_pkg::wdhc_core_t core,
  input wire logic irqEnabled,
  input wire logic stackFull,
  input wire logic [1:0] addr,
  input wire logic rdStb,
  input wire logic [7:0] rdData,
  input wire logic chipReset,
  input wire logic warmReset,
  input wire logic haltPin,
  input wire logic sysClkRun,
  input wire logic resumeNext,
  input wire logic resumeVector,
  input wire logic powerdownFlag,
  input wire logic watchdogExpiredFlag
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_halt;
    core.haltInstr && sysClkRun && !haltPin && externalInitPin_n
      && !chipReset |=> haltPin && powerdownFlag && !watchdogExpiredFlag;
  endproperty
  a_halt: assert property (p_halt) else $error("halt entry wrong");
  property p_warm;
    warmReset |-> ##[0:1] watchdogExpiredFlag;
  endproperty
  a_warm: assert property (p_warm) else $error("warm flag");
  property p_warm_halt;
    warmReset |-> $past(haltPin);
  endproperty
  a_warm_halt: assert property (p_warm_halt) else $error("warm run");
  property p_kick;
    core.kickSingle && KICK_MODE == wdhc_pkg::WDHC_KICK_ONE && sysClkRun
      && !chipReset |=> !powerdownFlag && !watchdogExpiredFlag;
  endproperty
  a_kick: assert property (p_kick) else $error("kick flags");
  property p_unmapped;
    rdStb && addr == 2'h2 |=> rdData == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  property p_ext;
    !externalInitPin_n |-> ##[1:2] chipReset;
  endproperty
  a_ext: assert property (p_ext) else $error("pin reset");
  property p_clk_stop;
    haltPin |-> !sysClkRun;
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("clk run");
  property p_vector;
    resumeVector |-> irqEnabled && !stackFull;
  endproperty
  a_vector: assert property (p_vector) else $error("vector");
  c_warm: cover property (warmReset);
  c_next: cover property (resumeNext);
  c_chip: cover property (chipReset);
endmodule : wdhc_asserts
bind wdhc_top wdhc_asserts #(.KICK_MODE(KICK_MODE)) u_asserts (.*);

//--- test/tb_top.sv
// Purpose: self-checking bench for the watchdog block
// Assumes: osc tick every clk, short wake count
// Notes: timeouts measured in clk cycles
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WK = 8;
  logic clk = 0, rst = 1, pinN = 1, osc = 1, go = 0;
  logic irqP = 0, irqE = 0, stk = 0, wrStb = 0, rdStb = 0;
  logic [1:0] addr = '0, op = '0;
  logic [7:0] portA = 8'hFF, wrData = '0, rdData;
  logic chipReset, warmReset, haltPin, sysClk, rNext, rVec, powerdown_flag, tof;
  wdhc_pkg::wdhc_core_t core;
  int err_count = 0, n_compared = 0, n, s;
  wdhc_core_model u_core (.clk(clk), .op(op), .go(go), .core(core));
  wdhc_top #(.WAKE_CYCLES(WK)) dut (.clk(clk), .rst(rst),
    .externalInitPin_n(pinN), .oscTick(osc), .core(core), .portA(portA),
    .irqPending(irqP), .irqEnabled(irqE), .stackFull(stk), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .chipReset(chipReset), .warmReset(warmReset), .haltPin(haltPin),
    .sysClkRun(sysClk), .resumeNext(rNext), .resumeVector(rVec),
    .powerdownFlag(powerdown_flag), .watchdogExpiredFlag(tof));
  always #5 clk = ~clk;
  // =====================================================================
  // tasks
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk) {addr, wrData, wrStb} <= {a, d, 1'b1};
    @(posedge clk) wrStb <= 1'b0;
  endtask : wr
  task rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk) {addr, rdStb} <= {a, 1'b1};
    @(posedge clk) rdStb <= 1'b0;
    @(negedge clk) check(rdData, exp);
  endtask : rd
  task cmd(input logic [1:0] o);
    @(posedge clk) {op, go} <= {o, 1'b1};
    @(posedge clk) go <= 1'b0;
  endtask : cmd
  // cycles until event w (0 chip, 1 warm, 2 next, 3 vector)
  task waitev(input int w, input int lim);
    n = 0;
    @(negedge clk);
    while (!(w == 0 ? chipReset : w == 1 ? warmReset : w == 2 ? rNext
        : rVec) && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : waitev
  task conclude;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    #200000;
    err_count++;
    conclude;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(2'h0, 8'h07);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h00);
    wr(2'h0, 8'hF8);
    rd(2'h0, 8'hF8);
    for (s = 0; s < 3; s++) begin
      repeat (200) @(posedge clk);
      cmd(2'h0);
    end
    waitev(0, 150);
    check(n == 150, 1);
    for (s = 0; s < 3; s++) begin
      wr(2'h0, 8'(s));
      cmd(2'h0);
      waitev(0, 1100);
      check(n >= (256 << s) - 4 && n <= (256 << s) + 6, 1);
      rd(2'h1, 8'h02);
    end
    rd(2'h0, 8'h07);
    cmd(2'h0);
    rd(2'h1, 8'h00);
    wr(2'h0, 8'h07);
    cmd(2'h3);
    repeat (2) @(negedge clk);
    check({haltPin, sysClk, powerdown_flag, tof}, 8'h0A);
    portA <= 8'hFE;
    waitev(2, 40);
    check(n >= WK - 2 && n <= WK + 3, 1);
    portA <= 8'hFF;
    irqP <= 1'b1;
    wr(2'h0, 8'h00);
    cmd(2'h3);
    waitev(1, 400);
    check(n > 200 && n < 400, 1);
    check(tof, 1);
    irqP <= 1'b0;
    irqE <= 1'b1;
    wr(2'h0, 8'hF7);
    cmd(2'h0);
    cmd(2'h3);
    repeat (3) @(posedge clk);
    irqP <= 1'b1;
    waitev(3, 40);
    check(n >= WK - 1 && n <= WK + 4, 1);
    irqP <= 1'b0;
    pinN <= 1'b0;
    waitev(0, 5);
    check(chipReset, 1);
    pinN <= 1'b1;
    repeat (3) @(posedge clk);
    rd(2'h0, 8'h07);
    conclude;
  end
endmodule : tb_top
